// *** logic/asoc_axis.sv ***
// Purpose: One axis of offset storage, slow loop and fast averaging
// Assumes: sample_vld marks a new filtered sample
// Notes: Internal offset is 12 bits, public copy is 8 bits
`timescale 1ns/10ps
module asoc_axis
    import asoc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic sample_vld,
    input wire logic signed [11:0] sample,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic clear,
    input wire logic slow_en,
    input wire logic cut_hi,
    input wire logic fast_go,
    input wire logic [1:0] target,
    output logic fast_done,
    output logic [7:0] pub_q,
    output logic signed [11:0] ofs_q
);
    typedef struct packed {
        logic signed [11:0] ofs;
        logic [7:0] pub;
        logic run;
        logic [4:0] cnt;
        logic signed [15:0] acc;
        logic done;
    } asoc_ax_t;
    asoc_ax_t s_q, s_d;
    logic signed [11:0] comp;
    logic signed [11:0] tgt;
    logic signed [15:0] diff;

    asoc_sat #(.W(12)) u_sat (.a(sample), .b(s_q.ofs), .y(comp));

    function automatic logic [7:0] narrow(input logic signed [15:0] v);
        logic signed [15:0] s;
        s = v >>> OFS_SHIFT;
        if (s > 16'sd127) begin
            narrow = 8'h7F;
        end else if (s < -16'sd128) begin
            narrow = 8'h80;
        end else begin
            narrow = s[7:0];
        end
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (target)
            TGT_PLUS: tgt = ONE_G;
            TGT_MINUS: tgt = -ONE_G;
            default: tgt = 12'sh000;
        endcase
        diff = 16'(tgt) - (s_q.acc >>> FAST_SHIFT);
        if (clear) begin
            s_d.ofs = 12'sh000;
            s_d.pub = REG_ZERO;
            s_d.run = 1'b0;
        end else if (load) begin
            s_d.pub = load_val;
            s_d.ofs = 12'($signed(load_val)) <<< OFS_SHIFT;
        end else if (s_q.done) begin
            // Result stored before trigger can restart run
            s_d.pub = narrow(diff);
            s_d.ofs = 12'($signed(narrow(diff))) <<< OFS_SHIFT;
        end else if (fast_go && !s_q.run) begin
            s_d.run = 1'b1;
            s_d.cnt = 5'h00;
            s_d.acc = 16'sh0000;
        end else if (s_q.run && sample_vld) begin
            s_d.acc = s_q.acc + 16'(sample);
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == 5'(FAST_SAMPLES - 1)) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end
        end else if (slow_en && sample_vld) begin
            s_d.ofs = s_q.ofs - (comp >>> (cut_hi ? HP_SHIFT_HI : HP_SHIFT_LO))
                - ((comp != 12'sh000) ? (comp[11] ? -12'sh001 : 12'sh001) : 12'sh000);
            s_d.pub = narrow(16'(s_d.ofs));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fast_done = s_q.done;
    assign pub_q = s_q.pub;
    assign ofs_q = s_q.ofs;

    a_fast_count: assert property (@(posedge clk) disable iff (srst)
        (s_q.run && sample_vld && s_q.cnt == 5'd15 && !clear && !load) |=> s_q.done)
        else $error("fast run did not finish after sixteen samples");
    a_clear_zero: assert property (@(posedge clk) disable iff (srst)
        clear |=> (s_q.pub == REG_ZERO && s_q.ofs == 12'sh000))
        else $error("clear did not zero offset");
endmodule // asoc_axis

// *** logic/asoc_pkg.sv ***
// Purpose: Shared constants for accelerometer self-test and offset compensation
// Assumes: Byte-wide register port, 12-bit samples
// Notes: Offsets are register addresses on the serial interface
package asoc_pkg;
    localparam logic [7:0] ADDR_SELF_TEST = 8'h32;
    localparam logic [7:0] ADDR_COMP_CTRL = 8'h36;
    localparam logic [7:0] ADDR_COMP_CFG = 8'h37;
    localparam logic [7:0] ADDR_OFS_X = 8'h38;
    localparam logic [7:0] ADDR_OFS_Y = 8'h39;
    localparam logic [7:0] ADDR_OFS_Z = 8'h3A;
    // Self-test control fields
    localparam int ST_AXIS_LSB = 0;
    localparam int ST_SIGN_BIT = 2;
    localparam int ST_AMP_BIT = 4;
    // Compensation control fields
    localparam int CC_HPX_BIT = 0;
    localparam int CC_HPY_BIT = 1;
    localparam int CC_HPZ_BIT = 2;
    localparam int CC_RDY_BIT = 4;
    localparam int CC_TRIG_LSB = 5;
    localparam int CC_CLR_BIT = 7;
    // Compensation config fields
    localparam int CF_CUTOFF_BIT = 0;
    localparam int CF_TGTX_LSB = 1;
    localparam int CF_TGTY_LSB = 3;
    localparam int CF_TGTZ_LSB = 5;
    localparam logic [1:0] AXIS_NONE = 2'h0;
    localparam logic [1:0] AXIS_X = 2'h1;
    localparam logic [1:0] AXIS_Y = 2'h2;
    localparam logic [1:0] AXIS_Z = 2'h3;
    localparam logic [1:0] TGT_PLUS = 2'h1;
    localparam logic [1:0] TGT_MINUS = 2'h2;
    // One g at 2 g range, 12-bit code
    localparam logic signed [11:0] ONE_G = 12'sh400;
    localparam int FAST_SAMPLES = 16;
    localparam int FAST_SHIFT = 4;
    localparam int OFS_SHIFT = 4;
    // Slow loop step shift for each corner setting
    localparam int HP_SHIFT_LO = 8;
    localparam int HP_SHIFT_HI = 4;
    localparam logic [7:0] REG_ZERO = 8'h00;
endpackage

// *** logic/asoc_sat.sv ***
// Purpose: Add offset to a sample with signed saturation
// Assumes: Both operands 12-bit two's complement
// Notes: Purely combinational
`timescale 1ns/10ps
module asoc_sat
    import asoc_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic signed [W-1:0] a,
    input wire logic signed [W-1:0] b,
    output logic signed [W-1:0] y
);
    logic signed [W:0] sum;
    always_comb begin
        sum = {a[W-1], a} + {b[W-1], b};
        if (sum[W] != sum[W-1]) begin
            y = sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            y = sum[W-1:0];
        end
    end
endmodule // asoc_sat

// *** logic/asoc_top.sv ***
// Purpose: Self-test control and offset compensation register block
// Assumes: Byte register port from the serial interface, same clock
// Notes: Nonvolatile image arrives on nvm_* ports with a load strobe
`timescale 1ns/10ps
// Behaviour
// - Two-bit axis field enables self-test on x, y or z; zero disables.
// - Polarity bit zero deflects negative, one deflects positive.
// - Active self-test output adds static offset to real acceleration.
// - Offsets apply to filtered and unfiltered data, saturating on overflow.
// - 8-bit public offsets widen to 12 bits; internal changes narrow back.
// - Image update copies stored offsets; host may overwrite anytime (a host write in the same cycle as a boot or image load is lost).
// - Writing one to clear bit zeros all offset registers.
// - Slow loop is first-order high-pass driving mean to zero.
// - Separate slow compensation enables for x, y, z.
// - Fast run averages 16 samples, stores target minus average.
// - Write-only trigger field starts fast run on x, y or z.
// - Ready bit is zero while fast run busy or trigger nonzero.
// - Per-axis target: 00 zero, 01 plus 1 g, 10 minus 1 g, 11 zero.
// - Every reset loads stored offsets from nonvolatile image.
module asoc_top
    import asoc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic nvm_load,
    input wire logic [7:0] nvm_ofs_x,
    input wire logic [7:0] nvm_ofs_y,
    input wire logic [7:0] nvm_ofs_z,
    input wire logic sample_vld,
    input wire logic signed [11:0] filt_x,
    input wire logic signed [11:0] filt_y,
    input wire logic signed [11:0] filt_z,
    input wire logic signed [11:0] unf_x,
    input wire logic signed [11:0] unf_y,
    input wire logic signed [11:0] unf_z,
    output logic signed [11:0] filt_out_x,
    output logic signed [11:0] filt_out_y,
    output logic signed [11:0] filt_out_z,
    output logic signed [11:0] unf_out_x,
    output logic signed [11:0] unf_out_y,
    output logic signed [11:0] unf_out_z,
    output logic [2:0] st_axis_en,
    output logic st_positive,
    output logic st_high_amp
);
    typedef struct packed {
        logic [7:0] st;
        logic [2:0] hp_en;
        logic [1:0] trig;
        logic [7:0] cfg;
        logic boot;
        logic [7:0] rdata;
        logic [2:0] st_en;
        logic st_pos;
        logic st_amp;
        logic signed [5:0][11:0] outs;
    } asoc_state_t;
    asoc_state_t s_q, s_d;

    logic [2:0] ax_load, ax_go, ax_done;
    logic [2:0][7:0] ax_pub, ax_nvm, ax_wval;
    logic [2:0][11:0] ax_ofs;
    logic [2:0][1:0] ax_tgt;
    logic [2:0][11:0] filt_in, unf_in, filt_c, unf_c;
    logic clr;
    logic busy;

    function automatic logic is_ofs(input logic [7:0] a, input int i);
        is_ofs = (a == ADDR_OFS_X + 8'(i));
    endfunction

    assign ax_nvm = {nvm_ofs_z, nvm_ofs_y, nvm_ofs_x};
    assign filt_in = {filt_z, filt_y, filt_x};
    assign unf_in = {unf_z, unf_y, unf_x};
    assign ax_tgt = {s_q.cfg[CF_TGTZ_LSB +: 2], s_q.cfg[CF_TGTY_LSB +: 2],
        s_q.cfg[CF_TGTX_LSB +: 2]};
    assign clr = reg_wr && reg_addr == ADDR_COMP_CTRL && reg_wdata[CC_CLR_BIT];
    assign busy = s_q.trig != AXIS_NONE;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ax
            // image update or host write; load at boot
            assign ax_load[g] = s_q.boot || nvm_load || (reg_wr && is_ofs(reg_addr, g));
            assign ax_wval[g] = (s_q.boot || nvm_load) ? ax_nvm[g] : reg_wdata;
            assign ax_go[g] = s_q.trig == 2'(g + 1);
            asoc_axis u_ax (
                .clk(clk),
                .srst(srst),
                .sample_vld(sample_vld),
                .sample(filt_in[g]),
                .load(ax_load[g]),
                .load_val(ax_wval[g]),
                .clear(clr),
                .slow_en(s_q.hp_en[g]),
                .cut_hi(s_q.cfg[CF_CUTOFF_BIT]),
                .fast_go(ax_go[g]),
                .target(ax_tgt[g]),
                .fast_done(ax_done[g]),
                .pub_q(ax_pub[g]),
                .ofs_q(ax_ofs[g])
            );
            asoc_sat #(.W(12)) u_sf (.a(filt_in[g]), .b(ax_ofs[g]), .y(filt_c[g]));
            asoc_sat #(.W(12)) u_su (.a(unf_in[g]), .b(ax_ofs[g]), .y(unf_c[g]));
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.boot = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_SELF_TEST: s_d.st = reg_wdata;
                ADDR_COMP_CTRL: begin
                    s_d.hp_en = {reg_wdata[CC_HPZ_BIT], reg_wdata[CC_HPY_BIT],
                        reg_wdata[CC_HPX_BIT]};
                    if (!busy) begin
                        s_d.trig = reg_wdata[CC_TRIG_LSB +: 2];
                    end
                end
                ADDR_COMP_CFG: s_d.cfg = reg_wdata;
                default: ;
            endcase
        end
        if (|ax_done || clr) begin
            s_d.trig = AXIS_NONE;
        end
        s_d.st_en = 3'h0;
        unique case (s_q.st[ST_AXIS_LSB +: 2])
            AXIS_X: s_d.st_en = 3'h1;
            AXIS_Y: s_d.st_en = 3'h2;
            AXIS_Z: s_d.st_en = 3'h4;
            default: ;
        endcase
        s_d.st_pos = s_q.st[ST_SIGN_BIT];
        s_d.st_amp = s_q.st[ST_AMP_BIT];
        // self-test offset rides on sensed data
        for (int i = 0; i < 3; i++) begin
            s_d.outs[i] = filt_c[i];
            s_d.outs[i + 3] = unf_c[i];
        end
        s_d.rdata = REG_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SELF_TEST: s_d.rdata = s_q.st;
                ADDR_COMP_CTRL: begin
                    s_d.rdata[CC_HPX_BIT] = s_q.hp_en[0];
                    s_d.rdata[CC_HPY_BIT] = s_q.hp_en[1];
                    s_d.rdata[CC_HPZ_BIT] = s_q.hp_en[2];
                    s_d.rdata[CC_RDY_BIT] = !busy;
                end
                ADDR_COMP_CFG: s_d.rdata = s_q.cfg;
                ADDR_OFS_X: s_d.rdata = ax_pub[0];
                ADDR_OFS_Y: s_d.rdata = ax_pub[1];
                ADDR_OFS_Z: s_d.rdata = ax_pub[2];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.boot <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign st_axis_en = s_q.st_en;
    assign st_positive = s_q.st_pos;
    assign st_high_amp = s_q.st_amp;
    assign filt_out_x = s_q.outs[0];
    assign filt_out_y = s_q.outs[1];
    assign filt_out_z = s_q.outs[2];
    assign unf_out_x = s_q.outs[3];
    assign unf_out_y = s_q.outs[4];
    assign unf_out_z = s_q.outs[5];

    sequence wr_st_x;
        reg_wr && reg_addr == ADDR_SELF_TEST && reg_wdata[1:0] == AXIS_X;
    endsequence
    a_st_axis_x: assert property (@(posedge clk) disable iff (srst)
        wr_st_x ##1 !(reg_wr && reg_addr == ADDR_SELF_TEST) |=> st_axis_en == 3'h1)
        else $error("x self-test not enabled");
    a_st_sign: assert property (@(posedge clk) disable iff (srst)
        ##1 st_positive == $past(s_q.st[ST_SIGN_BIT]))
        else $error("deflection sign mismatch");
    a_ready_low: assert property (@(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == ADDR_COMP_CTRL && busy) |=> !reg_rdata[CC_RDY_BIT])
        else $error("ready high while busy");
    a_trig_clear: assert property (@(posedge clk) disable iff (srst)
        (|ax_done) |=> s_q.trig == AXIS_NONE)
        else $error("trigger not cleared");
    a_boot_load: assert property (@(posedge clk)
        $fell(srst) |-> ##1 ax_pub[0] == $past(nvm_ofs_x))
        else $error("boot image not loaded");
    a_trig_start: assert property (@(posedge clk) disable iff (srst)
        ($rose(s_q.trig == AXIS_Y) && !clr && !ax_load[1]) |=> g_ax[1].u_ax.s_q.run)
        else $error("wrong axis triggered");
endmodule // asoc_top

// *** verif/asoc_host.sv ***
// Purpose: Host model driving the register port of the block
// Assumes: Strobes launched at the falling edge of clk
// Notes: Released address and data show the inverted last value
`timescale 1ns/10ps
module asoc_host
    import asoc_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask

    task automatic st(input logic [1:0] axis, input logic sign);
        wr(ADDR_SELF_TEST, {3'b000, 1'b1, 1'b0, sign, axis});
    endtask
endmodule // asoc_host

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for self-test and offset compensation
// Assumes: Inputs change at the falling edge of clk
// Notes: All register traffic goes through the host model
`timescale 1ns/10ps
module testbench
    import asoc_pkg::*;
;
    logic clk, srst, nvm_load, sample_vld, reg_wr, reg_rd, st_positive, st_high_amp;
    logic [7:0] nvm_ofs_x, nvm_ofs_y, nvm_ofs_z, reg_rdata, reg_addr, reg_wdata;
    logic signed [11:0] filt_x, filt_y, filt_z, unf_x, unf_y, unf_z;
    logic signed [11:0] filt_out_x, filt_out_y, filt_out_z, unf_out_x, unf_out_y, unf_out_z;
    logic [2:0] st_axis_en;
    int n_errors, samples_checked;

    asoc_top dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .nvm_load, .nvm_ofs_x, .nvm_ofs_y, .nvm_ofs_z, .sample_vld, .filt_x, .filt_y,
        .filt_z, .unf_x, .unf_y, .unf_z, .filt_out_x, .filt_out_y, .filt_out_z,
        .unf_out_x, .unf_out_y, .unf_out_z, .st_axis_en, .st_positive, .st_high_amp);
    asoc_host host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic close_out;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic err(input string msg);
        n_errors++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err($sformatf("got %h expected %h", got, exp));
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk({4'h0, d}, {4'h0, e});
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(negedge clk);
            sample_vld = 1'b1;
            @(negedge clk);
            sample_vld = 1'b0;
        end
    endtask

    // Power-on image and a later image update
    task automatic image_load;
        rchk(ADDR_OFS_X, 8'h12);
        rchk(ADDR_OFS_Y, 8'hE4);
        rchk(ADDR_OFS_Z, 8'h7F);
        nvm_ofs_x = 8'h21;
        nvm_ofs_y = 8'h43;
        nvm_ofs_z = 8'h65;
        @(negedge clk);
        nvm_load = 1'b1;
        @(negedge clk);
        nvm_load = 1'b0;
        repeat (2) @(negedge clk);
        rchk(ADDR_OFS_X, 8'h21);
        rchk(ADDR_OFS_Y, 8'h43);
        rchk(ADDR_OFS_Z, 8'h65);
        rchk(8'h40, 8'h00);
    endtask

    // Every axis code with both polarities
    task automatic self_test;
        logic [2:0] en;
        for (int a = 0; a < 4; a++) begin
            for (int s = 0; s < 2; s++) begin
                host.st(2'(a), 1'(s));
                repeat (2) @(negedge clk);
                en = (a == 0) ? 3'b000 : 3'b001 << (a - 1);
                chk({9'h0, st_axis_en}, {9'h0, en});
                chk({11'h0, st_positive}, 12'(s));
                chk({11'h0, st_high_amp}, 12'h001);
                rchk(ADDR_SELF_TEST, {3'b000, 1'b1, 1'b0, 1'(s), 2'(a)});
            end
        end
        host.st(AXIS_NONE, 1'b0);
    endtask

    // Manual offsets applied to both streams, with clamping
    task automatic manual_comp;
        host.wr(ADDR_OFS_X, 8'h7F);
        host.wr(ADDR_OFS_Y, 8'h80);
        host.wr(ADDR_OFS_Z, 8'h05);
        rchk(ADDR_OFS_Y, 8'h80);
        filt_x = 12'sh7FF;
        unf_x = 12'sh010;
        filt_y = -12'sh001;
        unf_y = 12'sh7FF;
        filt_z = 12'sh100;
        unf_z = 12'sh100;
        pulse(1);
        repeat (2) @(negedge clk);
        chk(filt_out_x, 12'h7FF);
        chk(unf_out_x, 12'h7FF);
        chk(filt_out_y, 12'h800);
        chk(unf_out_y, 12'hFFF);
        chk(filt_out_z, 12'h150);
        chk(unf_out_z, 12'h150);
        host.wr(ADDR_COMP_CTRL, 8'h80);
        for (int i = 0; i < 3; i++) begin
            rchk(ADDR_OFS_X + 8'(i), 8'h00);
        end
    endtask

    // One fast run on one axis
    task automatic fast_run(input logic [1:0] trig, input logic [7:0] cfg,
                            input logic signed [11:0] s, input logic [7:0] e);
        logic [7:0] d;
        int i;
        host.wr(ADDR_COMP_CFG, cfg);
        filt_x = s;
        filt_y = s;
        filt_z = s;
        host.wr(ADDR_COMP_CTRL, {1'b0, trig, 5'h00});
        host.rd(ADDR_COMP_CTRL, d);
        chk({9'h0, d[6:4]}, 12'h000);
        pulse(FAST_SAMPLES);
        i = 0;
        d = 8'h00;
        while (d[CC_RDY_BIT] !== 1'b1) begin
            host.rd(ADDR_COMP_CTRL, d);
            i++;
            if (i > 20) begin
                err("ready never returned");
                close_out();
            end
        end
        chk({9'h0, d[6:4]}, 12'h001);
        rchk(ADDR_OFS_X + 8'(trig) - 8'h01, e);
    endtask

    // Slow loop on x only pulls x offset negative
    task automatic slow_comp;
        logic [7:0] d;
        host.wr(ADDR_COMP_CTRL, 8'h80);
        host.wr(ADDR_COMP_CFG, 8'h01);
        filt_x = 12'sh600;
        filt_y = 12'sh600;
        filt_z = 12'sh600;
        host.wr(ADDR_COMP_CTRL, 8'h01);
        pulse(40);
        host.rd(ADDR_OFS_X, d);
        chk({11'h0, d[7]}, 12'h001);
        rchk(ADDR_OFS_Y, 8'h00);
        rchk(ADDR_OFS_Z, 8'h00);
        samples_checked++;
        if (!(filt_out_x < 12'sh600)) begin
            err("slow loop did not reduce x");
        end
        host.wr(ADDR_COMP_CTRL, 8'h00);
    endtask

    initial begin
        n_errors = 0;
        samples_checked = 0;
        srst = 1'b1;
        nvm_load = 1'b0;
        sample_vld = 1'b0;
        nvm_ofs_x = 8'h12;
        nvm_ofs_y = 8'hE4;
        nvm_ofs_z = 8'h7F;
        filt_x = 12'sh000;
        filt_y = 12'sh000;
        filt_z = 12'sh000;
        unf_x = 12'sh000;
        unf_y = 12'sh000;
        unf_z = 12'sh000;
        repeat (4) @(negedge clk);
        chk({4'h0, reg_rdata}, 12'h000);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        image_load();
        self_test();
        manual_comp();
        fast_run(AXIS_X, 8'h02, 12'sh300, 8'h10);
        fast_run(AXIS_Y, 8'h10, 12'sh100, 8'hB0);
        fast_run(AXIS_Z, 8'h40, 12'sh7F0, 8'h80);
        slow_comp();
        // Mid-run reset reloads stored image
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        rchk(ADDR_OFS_X, 8'h21);
        rchk(ADDR_OFS_Z, 8'h65);
        close_out();
    end
endmodule // testbench
